// file: pkg/guard_pkg.sv
// Constants shared by the guard timer configuration block and its core
package guard_pkg;
   // Register indices; byte address is four times the index
   localparam logic [1:0] IDX_CONTROL  = 2'h0;
   localparam logic [1:0] IDX_STATUS   = 2'h1;
   localparam logic [1:0] IDX_KEY      = 2'h2;
   localparam logic [1:0] IDX_RESTART  = 2'h3;
   localparam int         ADDR_W       = 4;
   // Field positions
   localparam int         WIN_MSB      = 7;
   localparam int         WIN_LSB      = 4;
   localparam int         PER_MSB      = 3;
   localparam int         PER_LSB      = 0;
   localparam int         LOCK_BIT     = 7;
   localparam int         BUSY_BIT     = 0;
   // Status reset value and restart key
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] RESTART_KEY  = 8'h5a;
   // Guard unlock value and how long the unlock stays open
   localparam logic [7:0] GUARD_KEY    = 8'hd8;
   localparam int         GUARD_CYCLES = 8;
   // Watchdog ticks needed to carry a value across the domains
   localparam int         SYNC_TICKS   = 2;
   localparam logic [3:0] CODE_OFF     = 4'h0;
   localparam logic [3:0] CODE_MAX     = 4'hb;
   localparam int         CNT_W        = 14;
   localparam int         BASE_SHIFT   = 2;

   // Period length in watchdog ticks; reserved codes act as the longest
   function automatic logic [CNT_W-1:0] code_ticks(input logic [3:0] code);
      logic [3:0] c;
      c = (code > CODE_MAX) ? CODE_MAX : code;
      code_ticks = '0;
      if (c != CODE_OFF)
      begin
         code_ticks = CNT_W'(1) << (c + 4'(BASE_SHIFT));
      end
   endfunction
endpackage

// file: logic/guard_counter.sv
// Counting core: normal and windowed time-out with restart handling
`timescale 1ns/1ps
module guard_counter
   import guard_pkg::*;
(
   input  wire logic       clk,          // System clock
   input  wire logic       rst,          // Async reset, active high
   input  wire logic       tick,         // Watchdog oscillator tick
   input  wire logic [3:0] win_code,     // Closed period code
   input  wire logic [3:0] per_code,     // Time-out / open period code
   input  wire logic       restart,      // Restart request pulse
   input  wire logic       debug_mode,   // CPU halted in debug
   output logic            restart_busy, // Restart being synchronised
   output logic            sys_reset     // System reset request pulse
);
   typedef enum logic [3:0] {
      ST_OFF    = 4'b0001,
      ST_FIRST  = 4'b0010,
      ST_CLOSED = 4'b0100,
      ST_OPEN   = 4'b1000
   } cnt_state_e;

   cnt_state_e             state;
   logic [CNT_W-1:0]       cnt;
   logic [CNT_W-1:0]       cnt_inc;
   logic [1:0]             rs_ticks;
   logic                   apply;
   logic                   enabled;
   logic                   windowed;

   assign enabled  = (per_code != CODE_OFF);  // [R3]
   assign windowed = (win_code != CODE_OFF);  // [R1]
   assign cnt_inc  = cnt + CNT_W'(1);
   assign apply    = restart_busy && tick && (rs_ticks == 2'(SYNC_TICKS - 1));

   // Restart crossing; a second restart while one is pending is dropped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         restart_busy <= 1'b0;
         rs_ticks     <= 2'h0;
      end
      else if (restart && !restart_busy)
      begin
         restart_busy <= 1'b1;
         rs_ticks     <= 2'h0;
      end
      else if (restart_busy && tick)
      begin
         rs_ticks <= rs_ticks + 2'h1;
         if (apply)
         begin
            restart_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state     <= ST_OFF;
         cnt       <= '0;
         sys_reset <= 1'b0;
      end
      else
      begin
         sys_reset <= 1'b0;
         if (!enabled)
         begin
            state <= ST_OFF;
            cnt   <= '0;
         end
         else if (debug_mode)
         begin
            // Halted: counter cleared, resume with a plain time-out
            state <= ST_FIRST;
            cnt   <= '0;
         end
         else
         begin
            case (state)
               ST_OFF:
               begin
                  state <= ST_FIRST;
                  cnt   <= '0;
               end
               ST_FIRST:
               begin
                  if (apply)
                  begin
                     state <= windowed ? ST_CLOSED : ST_FIRST;
                     cnt   <= '0;
                  end
                  else if (tick && cnt_inc >= code_ticks(per_code))
                  begin
                     sys_reset <= 1'b1;  // [R12]
                     cnt       <= '0;
                  end
                  else if (tick)
                  begin
                     cnt <= cnt_inc;
                  end
               end
               ST_CLOSED:
               begin
                  if (!windowed)
                  begin
                     state <= ST_FIRST;
                     cnt   <= '0;
                  end
                  else if (apply)
                  begin
                     sys_reset <= 1'b1;  // [R13]
                     state     <= ST_FIRST;
                     cnt       <= '0;
                  end
                  else if (tick && cnt_inc >= code_ticks(win_code))
                  begin
                     state <= ST_OPEN;   // [R2]
                     cnt   <= '0;
                  end
                  else if (tick)
                  begin
                     cnt <= cnt_inc;
                  end
               end
               ST_OPEN:
               begin
                  if (!windowed)
                  begin
                     state <= ST_FIRST;
                     cnt   <= '0;
                  end
                  else if (apply)
                  begin
                     state <= ST_CLOSED;
                     cnt   <= '0;
                  end
                  else if (tick && cnt_inc >= code_ticks(per_code))
                  begin
                     sys_reset <= 1'b1;  // [R4]
                     state     <= ST_FIRST;
                     cnt       <= '0;
                  end
                  else if (tick)
                  begin
                     cnt <= cnt_inc;
                  end
               end
               default:
               begin
                  state <= ST_OFF;
                  cnt   <= '0;
               end
            endcase
         end
      end
   end

   closed_needs_window_a: assert property (  // [R1]
      @(posedge clk) disable iff (rst)
      (state == ST_CLOSED) |-> windowed)
      else $error("Closed period without window mode");

   closed_length_a: assert property (  // [R2]
      @(posedge clk) disable iff (rst)
      (state == ST_CLOSED && windowed && enabled && !debug_mode && !apply
       && tick && cnt_inc >= code_ticks(win_code)) |=> (state == ST_OPEN))
      else $error("Closed period overran its length");

   timeout_fires_a: assert property (  // [R12]
      @(posedge clk) disable iff (rst)
      (state == ST_FIRST && enabled && !debug_mode && !apply && tick
       && cnt_inc >= code_ticks(per_code)) |=> sys_reset)
      else $error("Missed time-out reset");

   open_expiry_a: assert property (  // [R4]
      @(posedge clk) disable iff (rst)
      (state == ST_OPEN && windowed && enabled && !debug_mode && !apply
       && tick && cnt_inc >= code_ticks(per_code)) |=> sys_reset)
      else $error("Open window expiry did not reset");

   early_restart_a: assert property (  // [R13]
      @(posedge clk) disable iff (rst)
      (state == ST_CLOSED && windowed && enabled && !debug_mode && apply)
      |=> sys_reset ##1 !sys_reset)
      else $error("Restart in closed period not punished");

   off_quiet_a: assert property (  // [R3]
      @(posedge clk) disable iff (rst)
      !enabled |=> (state == ST_OFF) && !sys_reset)
      else $error("Disabled guard still active");

   open_reached_c: cover property (
      @(posedge clk) disable iff (rst) state == ST_OPEN);
   early_reset_c: cover property (
      @(posedge clk) disable iff (rst)
      state == ST_CLOSED && apply && windowed && enabled && !debug_mode);
endmodule

// file: logic/guard_timer.sv
// Guard timer register file, protection, domain transfer and core
`timescale 1ns/1ps
// What this block does
// [R1] Non-zero window field selects window mode
// [R2] Window code sets closed length, doubling from 8
// [R3] Non-zero period field enables, sets time-out
// [R4] In window mode period field is open length
// [R5] Lock set makes control register read-only
// [R6] Lock set by software or after boot; clear in debug
// [R7] Period non-zero after boot sets lock
// [R8] Control write raises sync pending flag
// [R9] Flag clears itself when transfer completes
// [R10] Lock is key-guarded; pending flag is not
// [R11] Control reset value comes from boot fuse
// [R12] Missing restart before time-out resets system
// [R13] Restart during closed period resets system
// [R14] Software avoids control writes while pending
// [R15] Blocked control writes are silently dropped
module guard_timer
   import guard_pkg::*;
(
   input  wire logic              clk,                    // System clock
   input  wire logic              rst,                    // Async reset
   input  wire logic [ADDR_W-1:0] address,                // Byte address
   input  wire logic              read,                   // Read strobe
   input  wire logic              write,                  // Write strobe
   input  wire logic [3:0]        byteenable,             // Byte lanes
   input  wire logic [31:0]       writedata,              // Write data
   output logic [31:0]            readdata,               // Read data
   output logic                   waitrequest,            // Bus stall
   input  wire logic              wdt_tick,               // Oscillator tick
   input  wire logic [7:0]        boot_fuse_guard_setting, // Fuse value
   input  wire logic              boot_done,              // Boot finished
   input  wire logic              debug_mode,             // CPU in debug
   output logic                   restart_busy,           // Restart syncing
   output logic                   system_reset            // Reset request
);
   logic [7:0]             guard_control_reg;
   logic [7:0]             applied_ctrl;
   logic                   lock;
   logic                   sync_pending_flag;
   logic [1:0]             sync_ticks;
   logic                   loading;
   logic                   ack;
   logic [3:0]             guard_open_cnt;
   logic                   guard_open;
   logic                   take_wr;
   logic                   take_rd;
   logic [1:0]             idx;
   logic                   ctrl_wr;
   logic                   ctrl_ok;
   logic                   stat_wr;
   logic                   key_wr;
   logic                   rst_wr;
   logic                   boot_lock;
   logic                   sync_done;
   logic [7:0]             next_readdata;

   // Bus answer: request taken on its second edge
   assign waitrequest = (read || write) && !ack;
   assign take_wr     = write && ack;
   assign take_rd     = read && !ack;
   assign idx         = address[3:2];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= (read || write) && !ack;
      end
   end

   assign ctrl_wr = take_wr && byteenable[0] && idx == IDX_CONTROL
                    && address[1:0] == 2'h0;
   assign stat_wr = take_wr && byteenable[0] && idx == IDX_STATUS
                    && address[1:0] == 2'h0;
   assign key_wr  = take_wr && byteenable[0] && idx == IDX_KEY
                    && address[1:0] == 2'h0;
   assign rst_wr  = take_wr && byteenable[0] && idx == IDX_RESTART
                    && address[1:0] == 2'h0
                    && writedata[7:0] == RESTART_KEY;
   assign ctrl_ok = ctrl_wr && guard_open && !lock;  // [R5] [R10] [R15]

   // Guard unlock window, used up by one protected write
   assign guard_open = (guard_open_cnt != 4'h0);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         guard_open_cnt <= 4'h0;
      end
      else if (key_wr && writedata[7:0] == GUARD_KEY)
      begin
         guard_open_cnt <= 4'(GUARD_CYCLES);
      end
      else if ((ctrl_wr || stat_wr) && guard_open)
      begin
         guard_open_cnt <= 4'h0;  // [R10]
      end
      else if (guard_open)
      begin
         guard_open_cnt <= guard_open_cnt - 4'h1;
      end
   end

   // Control register: fuse value after reset, guarded writes after
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loading           <= 1'b1;
         guard_control_reg <= 8'h00;
      end
      else if (loading)
      begin
         loading           <= 1'b0;
         guard_control_reg <= boot_fuse_guard_setting;  // [R11]
      end
      else if (ctrl_ok)
      begin
         guard_control_reg <= writedata[7:0];  // [R5] [R15]
      end
   end

   // Lock: software sets with key; clears only in debug with key
   assign boot_lock = boot_done && !loading
                      && guard_control_reg[PER_MSB:PER_LSB] != CODE_OFF;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lock <= STATUS_RESET[LOCK_BIT];
      end
      else if (boot_lock)
      begin
         lock <= 1'b1;  // [R7]
      end
      else if (stat_wr && guard_open)
      begin
         if (writedata[LOCK_BIT])
         begin
            lock <= 1'b1;  // [R6]
         end
         else if (debug_mode)
         begin
            lock <= 1'b0;  // [R6]
         end
      end
   end

   // Transfer of the control value into the watchdog tick domain
   assign sync_done = sync_pending_flag && wdt_tick
                      && sync_ticks == 2'(SYNC_TICKS - 1);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync_pending_flag <= STATUS_RESET[BUSY_BIT];
         sync_ticks        <= 2'h0;
         applied_ctrl      <= 8'h00;
      end
      else if (loading)
      begin
         applied_ctrl <= boot_fuse_guard_setting;  // [R11]
      end
      else if (ctrl_ok)
      begin
         // A write while pending restarts the transfer
         sync_pending_flag <= 1'b1;  // [R8] [R14]
         sync_ticks        <= 2'h0;
      end
      else if (sync_pending_flag && wdt_tick)
      begin
         sync_ticks <= sync_ticks + 2'h1;
         if (sync_done)
         begin
            sync_pending_flag <= 1'b0;  // [R9]
            applied_ctrl      <= guard_control_reg;
         end
      end
   end

   // Read data captured on the first edge, valid at the taking edge
   always_comb
   begin
      next_readdata = 8'h00;
      if (address[1:0] == 2'h0)
      begin
         case (idx)
            IDX_CONTROL: next_readdata = guard_control_reg;
            IDX_STATUS:
            begin
               next_readdata[LOCK_BIT] = lock;
               next_readdata[BUSY_BIT] = sync_pending_flag;
            end
            default:     next_readdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         readdata <= 32'h0000_0000;
      end
      else if (take_rd)
      begin
         readdata <= {24'h00_0000, next_readdata};
      end
   end

   guard_counter i_guard_counter
   (
      .clk          (clk),
      .rst          (rst),
      .tick         (wdt_tick),
      .win_code     (applied_ctrl[WIN_MSB:WIN_LSB]),
      .per_code     (applied_ctrl[PER_MSB:PER_LSB]),
      .restart      (rst_wr),
      .debug_mode   (debug_mode),
      .restart_busy (restart_busy),
      .sys_reset    (system_reset)
   );

   bus_answer_a: assert property (
      @(posedge clk) disable iff (rst)
      ((read || write) && !ack) |=> !waitrequest)
      else $error("Bus request not answered next cycle");

   lock_freeze_a: assert property (  // [R5]
      @(posedge clk) disable iff (rst)
      (lock && ctrl_wr && !loading) |=> $stable(guard_control_reg))
      else $error("Locked control register changed");

   unguarded_drop_a: assert property (  // [R15]
      @(posedge clk) disable iff (rst)
      (ctrl_wr && !guard_open && !loading)
      |=> $stable(guard_control_reg) && !$rose(sync_pending_flag))
      else $error("Unguarded control write took effect");

   lock_sticky_a: assert property (  // [R6]
      @(posedge clk) disable iff (rst)
      (lock && !debug_mode) |=> lock)
      else $error("Lock cleared outside debug");

   lock_guarded_a: assert property (  // [R10]
      @(posedge clk) disable iff (rst)
      (stat_wr && !guard_open && !boot_lock) |=> $stable(lock))
      else $error("Lock changed without guard key");

   boot_lock_a: assert property (  // [R7]
      @(posedge clk) disable iff (rst)
      boot_lock |=> lock)
      else $error("Lock not set after boot");

   busy_rise_a: assert property (  // [R8]
      @(posedge clk) disable iff (rst)
      (ctrl_ok && !loading) |=> sync_pending_flag)
      else $error("Pending flag not raised by control write");

   busy_clear_a: assert property (  // [R9]
      @(posedge clk) disable iff (rst)
      (sync_done && !ctrl_ok)
      |=> !sync_pending_flag && applied_ctrl == $past(guard_control_reg))
      else $error("Transfer did not complete");

   fuse_load_a: assert property (  // [R11]
      @(posedge clk) disable iff (rst)
      loading |=> guard_control_reg == $past(boot_fuse_guard_setting)
      && applied_ctrl == $past(boot_fuse_guard_setting))
      else $error("Fuse value not loaded");

   locked_write_c: cover property (
      @(posedge clk) disable iff (rst) lock && ctrl_wr && guard_open);
   transfer_c: cover property (
      @(posedge clk) disable iff (rst) sync_done);
   timeout_c: cover property (
      @(posedge clk) disable iff (rst) system_reset);
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the guard timer register and protection block
`timescale 1ns/1ps
module tb_top;
   import guard_pkg::*;

   localparam logic [3:0] A_CTL = {IDX_CONTROL, 2'b00};
   localparam logic [3:0] A_STA = {IDX_STATUS, 2'b00};
   localparam logic [3:0] A_KEY = {IDX_KEY, 2'b00};
   localparam logic [3:0] A_RST = {IDX_RESTART, 2'b00};

   logic              clk;
   logic              rst;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [3:0]        byteenable;
   logic [31:0]       writedata;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic              wdt_tick;
   logic [7:0]        fuse;
   logic              boot_done;
   logic              debug_mode;
   logic              restart_busy;
   logic              system_reset;
   logic [31:0]       rd;
   int                n_errors;
   int                check_count;
   int                n_rst = 0;
   int                base;

   guard_timer i_guard_timer (
      .clk                     (clk),
      .rst                     (rst),
      .address                 (address),
      .read                    (read),
      .write                   (write),
      .byteenable              (byteenable),
      .writedata               (writedata),
      .readdata                (readdata),
      .waitrequest             (waitrequest),
      .wdt_tick                (wdt_tick),
      .boot_fuse_guard_setting (fuse),
      .boot_done               (boot_done),
      .debug_mode              (debug_mode),
      .restart_busy            (restart_busy),
      .system_reset            (system_reset)
   );

   always #2.5 clk = ~clk;

   // Counts cycles with the reset request high
   always @(posedge clk)
   begin
      if (system_reset === 1'b1)
      begin
         n_rst <= n_rst + 1;
      end
   end

   task automatic close_out();
      if (n_errors == 0 && check_count > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic we, input logic [3:0] addr,
                      input logic [7:0] wd, output logic [31:0] rdata);
      int n;
      n = 0;
      @(posedge clk);
      address   <= addr;
      writedata <= {24'h000000, wd};
      write     <= we;
      read      <= ~we;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 16);
      if (waitrequest !== 1'b0)
      begin
         n_errors++;
         close_out();
      end
      else
      begin
         rdata = readdata;
         write <= 1'b0;
         read  <= 1'b0;
      end
   endtask

   task automatic wr(input logic [3:0] addr, input logic [7:0] wd);
      logic [31:0] unused;
      bus(1'b1, addr, wd, unused);
   endtask

   // Key write then the protected write
   task automatic gwr(input logic [3:0] addr, input logic [7:0] wd);
      wr(A_KEY, GUARD_KEY);
      wr(addr, wd);
   endtask

   task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, addr, 8'h00, v);
      check(v, exp);
   endtask

   // Oscillator ticks, one every four system cycles
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge clk);
         wdt_tick <= 1'b1;
         @(posedge clk);
         wdt_tick <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      close_out();
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h1;
      writedata = '0;
      wdt_tick = 1'b0;
      fuse = 8'h00;
      boot_done = 1'b0;
      debug_mode = 1'b0;
      n_errors = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(A_STA, 32'h00);
      rd_chk(A_CTL, 32'h00);
      rd_chk(A_KEY, 32'h00);
      rd_chk(4'h2, 32'h00);
      wr(A_CTL, 8'h35);
      rd_chk(A_CTL, 32'h00);
      // Normal mode, eight-tick time-out
      gwr(A_CTL, 8'h01);
      rd_chk(A_STA, 32'h01);
      rd_chk(A_CTL, 32'h01);
      ticks(3);
      rd_chk(A_STA, 32'h00);
      base = n_rst;
      repeat (4)
      begin
         wr(A_RST, RESTART_KEY);
         ticks(4);
      end
      check(32'(n_rst), 32'(base));
      ticks(4);
      check(32'(n_rst), 32'(base));
      ticks(4);
      check(32'(n_rst), 32'(base + 1));
      // Switched off: no time-out
      gwr(A_CTL, 8'h00);
      ticks(3);
      base = n_rst;
      ticks(12);
      check(32'(n_rst), 32'(base));
      // Window mode, closed and open both eight ticks
      gwr(A_CTL, 8'h11);
      ticks(3);
      base = n_rst;
      wr(A_RST, RESTART_KEY);
      @(negedge clk);
      check({31'h0, restart_busy}, 32'h1);
      ticks(3);
      wr(A_RST, RESTART_KEY);
      ticks(3);
      check(32'(n_rst), 32'(base + 1));
      wr(A_RST, RESTART_KEY);
      ticks(11);
      wr(A_RST, RESTART_KEY);
      ticks(3);
      check(32'(n_rst), 32'(base + 1));
      ticks(20);
      check(32'(n_rst), 32'(base + 2));
      // Lock and change guard
      wr(A_STA, 8'h80);
      rd_chk(A_STA, 32'h00);
      gwr(A_STA, 8'h81);
      rd_chk(A_STA, 32'h80);
      gwr(A_CTL, 8'h22);
      rd_chk(A_CTL, 32'h11);
      rd_chk(A_STA, 32'h80);
      gwr(A_STA, 8'h00);
      rd_chk(A_STA, 32'h80);
      debug_mode <= 1'b1;
      gwr(A_STA, 8'h00);
      rd_chk(A_STA, 32'h00);
      debug_mode <= 1'b0;
      // Fuse-loaded control and lock after boot
      fuse <= 8'h13;
      rst  <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(A_CTL, 32'h13);
      boot_done <= 1'b1;
      @(posedge clk);
      boot_done <= 1'b0;
      bus(1'b0, A_STA, 8'h00, rd);
      check(rd & 32'h80, 32'h80);
      gwr(A_CTL, 8'h00);
      rd_chk(A_CTL, 32'h13);
      close_out();
   end
endmodule
